/* File: inc/dma_addr_map.vh */
`ifndef DMA_ADDR_MAP_VH
`define DMA_ADDR_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_ADDR_CTRL 8'h00
`define OFS_SRC_ADDR 8'h04
`define OFS_DST_ADDR 8'h08
`define OFS_COUNT 8'h0c
`define OFS_CHAN_CTRL 8'h10
`define OFS_STATUS 8'h14

// ----------------------------------------------------------------
// Address control fields
// ----------------------------------------------------------------
`define POS_MODE_SEL 31
`define POS_DIRECTION 30
`define POS_SRC_STEP_HI 21
`define POS_SRC_STEP_LO 20
`define POS_DST_STEP_HI 17
`define POS_DST_STEP_LO 16
`define ADDR_CTRL_WMASK 32'hc7339f9f
`define ADDR_CTRL_RESET 32'h00000000

// ----------------------------------------------------------------
// Channel control and status fields
// ----------------------------------------------------------------
`define POS_ACK_EN 0
`define POS_CHAN_EN 1
`define POS_ST_BUSY 0
`define POS_ST_DONE 1
`define POS_ST_DIR 2
`define POS_ST_MODE 3
`define COUNT_W 16
`define COUNT_RESET 16'h0000
`define ADDR_RESET 32'h00000000
`define STEP_UNIT 32'h00000001

`endif

/* File: hdl/dma_channel_pins.v */
`timescale 1ns/1ns
`default_nettype none

module dma_channel_pins (
	input wire pclk,
	input wire presetn,
	input wire dma_req_n,
	input wire ack_req,
	input wire single_mode,
	input wire ack_enable,
	output wire req_level,
	output reg dma_ack_pin_n,
	output reg dma_ack_oe
);

// ----------------------------------------------------------------
// Request pin synchroniser
// ----------------------------------------------------------------
reg req_meta;
reg req_sync;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		req_meta <= 1'b0;
		req_sync <= 1'b0;
	end else begin
		req_meta <= ~dma_req_n;
		req_sync <= req_meta;
	end
end

assign req_level = req_sync;

// ----------------------------------------------------------------
// Acknowledge pin driver
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		dma_ack_pin_n <= 1'b1;
		dma_ack_oe <= 1'b0;
	end else begin
		dma_ack_oe <= single_mode & ack_enable;
		dma_ack_pin_n <= ~(single_mode & ack_enable & ack_req);
	end
end

endmodule
`default_nettype wire

/* File: hdl/dma_address_mode_control.v */
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "dma_addr_map.vh"

module dma_address_mode_control (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire dma_req_n,
	output wire dma_ack_pin_n,
	output wire dma_ack_oe,
	output reg [31:0] bus_addr,
	output reg bus_read,
	output reg bus_write,
	output reg [31:0] bus_wdata,
	input wire [31:0] bus_rdata,
	output reg address_mode_select,
	output reg single_addr_direction,
	output reg busy
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [2:0] st_idle = 3'b000;
localparam [2:0] st_read = 3'b001;
localparam [2:0] st_write = 3'b010;
localparam [2:0] st_single = 3'b011;
localparam [2:0] st_release = 3'b100;

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [31:0] dma_address_control;
reg [31:0] source_address_reg;
reg [31:0] destination_address_reg;
reg [`COUNT_W-1:0] transfer_count;
reg ack_pin_enable;
reg chan_enable;
reg done_flag;
reg ack_req;
reg [2:0] state;
reg [31:0] next_rdata;
reg next_err;
wire req_level;
wire access;
wire wr_fire;
wire mode_single;
wire dir_eff;
wire count_last;

// ----------------------------------------------------------------
// Decoding helpers
// ----------------------------------------------------------------
function is_mapped;
	input [7:0] a;
	begin
		is_mapped = (a == `OFS_ADDR_CTRL) || (a == `OFS_SRC_ADDR) ||
			(a == `OFS_DST_ADDR) || (a == `OFS_COUNT) ||
			(a == `OFS_CHAN_CTRL) || (a == `OFS_STATUS);
	end
endfunction

function [31:0] step_next;
	input [31:0] addr;
	input [1:0] mode;
	begin
		case (mode)
			2'b10: step_next = addr + `STEP_UNIT;
			2'b11: step_next = addr - `STEP_UNIT;
			default: step_next = addr;
		endcase
	end
endfunction

assign access = psel & penable;
assign wr_fire = access & pready & pwrite & is_mapped(paddr);
assign mode_single = dma_address_control[`POS_MODE_SEL];
assign dir_eff = mode_single & dma_address_control[`POS_DIRECTION];
assign count_last = (transfer_count == {{(`COUNT_W-1){1'b0}}, 1'b1});

// ----------------------------------------------------------------
// Pin logic
// ----------------------------------------------------------------
dma_channel_pins u_pins (
	.pclk(pclk),
	.presetn(presetn),
	.dma_req_n(dma_req_n),
	.ack_req(ack_req),
	.single_mode(mode_single),
	.ack_enable(ack_pin_enable),
	.req_level(req_level),
	.dma_ack_pin_n(dma_ack_pin_n),
	.dma_ack_oe(dma_ack_oe)
);

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @* begin
	next_rdata = 32'h00000000;
	next_err = 1'b0;
	case (paddr)
		`OFS_ADDR_CTRL: next_rdata = dma_address_control & `ADDR_CTRL_WMASK;
		`OFS_SRC_ADDR: next_rdata = source_address_reg;
		`OFS_DST_ADDR: next_rdata = destination_address_reg;
		`OFS_COUNT: next_rdata = {{(32-`COUNT_W){1'b0}}, transfer_count};
		`OFS_CHAN_CTRL: begin
			next_rdata[`POS_ACK_EN] = ack_pin_enable;
			next_rdata[`POS_CHAN_EN] = chan_enable;
		end
		`OFS_STATUS: begin
			next_rdata[`POS_ST_BUSY] = busy;
			next_rdata[`POS_ST_DONE] = done_flag;
			next_rdata[`POS_ST_DIR] = dir_eff;
			next_rdata[`POS_ST_MODE] = mode_single;
		end
		default: next_err = 1'b1;
	endcase
end

// ----------------------------------------------------------------
// APB answer
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end else begin
		pready <= access & ~pready;
		if (access & ~pready) begin
			prdata <= pwrite ? 32'h00000000 : next_rdata;
			pslverr <= next_err;
		end else begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// Registers and transfer engine
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		dma_address_control <= `ADDR_CTRL_RESET;
		source_address_reg <= `ADDR_RESET;
		destination_address_reg <= `ADDR_RESET;
		transfer_count <= `COUNT_RESET;
		ack_pin_enable <= 1'b0;
		chan_enable <= 1'b0;
		done_flag <= 1'b0;
		ack_req <= 1'b0;
		state <= st_idle;
		bus_addr <= 32'h00000000;
		bus_read <= 1'b0;
		bus_write <= 1'b0;
		bus_wdata <= 32'h00000000;
		address_mode_select <= 1'b0;
		single_addr_direction <= 1'b0;
		busy <= 1'b0;
	end else begin
		address_mode_select <= mode_single;
		single_addr_direction <= dir_eff;
		busy <= (state != st_idle);
		if (wr_fire) begin
			case (paddr)
				`OFS_ADDR_CTRL:
					dma_address_control <= pwdata & `ADDR_CTRL_WMASK;
				`OFS_SRC_ADDR: source_address_reg <= pwdata;
				`OFS_DST_ADDR: destination_address_reg <= pwdata;
				`OFS_COUNT: transfer_count <= pwdata[`COUNT_W-1:0];
				`OFS_CHAN_CTRL: begin
					ack_pin_enable <= pwdata[`POS_ACK_EN];
					chan_enable <= pwdata[`POS_CHAN_EN];
				end
				`OFS_STATUS:
					if (pwdata[`POS_ST_DONE])
						done_flag <= 1'b0;
				default: done_flag <= done_flag;
			endcase
		end
		case (state)
			st_idle: begin
				if (chan_enable && (transfer_count != `COUNT_RESET) && req_level) begin
					if (mode_single) begin
						state <= st_single;
						bus_addr <= dir_eff ? destination_address_reg :
							source_address_reg;
						bus_read <= ~dir_eff;
						bus_write <= dir_eff;
						ack_req <= 1'b1;
					end else begin
						state <= st_read;
						bus_addr <= source_address_reg;
						bus_read <= 1'b1;
					end
				end
			end
			st_read: begin
				bus_read <= 1'b0;
				bus_write <= 1'b1;
				bus_addr <= destination_address_reg;
				bus_wdata <= bus_rdata;
				state <= st_write;
			end
			st_write, st_single: begin
				bus_read <= 1'b0;
				bus_write <= 1'b0;
				ack_req <= 1'b0;
				if (!mode_single || !dir_eff)
					source_address_reg <= step_next(source_address_reg,
						dma_address_control[`POS_SRC_STEP_HI:`POS_SRC_STEP_LO]);
				if (!mode_single || dir_eff)
					destination_address_reg <= step_next(destination_address_reg,
						dma_address_control[`POS_DST_STEP_HI:`POS_DST_STEP_LO]);
				transfer_count <= transfer_count - {{(`COUNT_W-1){1'b0}}, 1'b1};
				if (count_last) begin
					done_flag <= 1'b1;
					chan_enable <= 1'b0;
				end
				state <= st_release;
			end
			st_release: begin
				if (!req_level)
					state <= st_idle;
			end
			default: state <= st_idle;
		endcase
	end
end

endmodule
`default_nettype wire

/* File: tb/mode_ctrl_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ------
// Checks
// ------
module mode_ctrl_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire dma_ack_pin_n,
	input wire dma_ack_oe,
	input wire bus_read,
	input wire bus_write,
	input wire address_mode_select,
	input wire single_addr_direction
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr0 = psel && penable && pready && pwrite && paddr == 8'h00;
	wire rd0 = pready && !pwrite && paddr == 8'h00;
	mode_copy_a: assert property (wr0 |-> ##2 address_mode_select == $past(pwdata[31], 2))
		else $error("mode bit not copied");
	dir_gate_a: assert property (single_addr_direction |-> address_mode_select)
		else $error("direction active in dual mode");
	ack_oe_a: assert property (dma_ack_oe |-> address_mode_select || $past(address_mode_select))
		else $error("ack pin enabled in dual mode");
	ack_pulse_a: assert property ($fell(dma_ack_pin_n) |-> dma_ack_oe ##1 dma_ack_pin_n)
		else $error("ack pulse wrong");
	ack_dir_a: assert property ($fell(dma_ack_pin_n) |->
		($past(single_addr_direction) ? $past(bus_write) : $past(bus_read)))
		else $error("ack after wrong strobe");
	rsv_zero_a: assert property (rd0 |-> prdata[29:27] == 3'h0)
		else $error("reserved bits not zero");
	rsv_ro_a: assert property (rd0 |-> (prdata & ~32'hc7339f9f) == 32'h0)
		else $error("read-only bits not zero");
	acc_len_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("access length wrong");
	cover property (wr0);
	cover property ($fell(dma_ack_pin_n));
	cover property (rd0 && prdata[31]);
endmodule
bind dma_address_mode_control mode_ctrl_props u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .dma_ack_pin_n, .dma_ack_oe, .bus_read,
	.bus_write, .address_mode_select, .single_addr_direction);
`default_nettype wire

/* File: tb/ack_side_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------
// Requesting peripheral and memory
// ------
module ack_side_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic dma_ack_pin_n,
	input wire logic dma_ack_oe,
	input wire logic bus_read,
	input wire logic bus_write,
	output logic dma_req_n,
	output logic [31:0] bus_rdata,
	output logic [7:0] ack_count
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_req_n <= 1'b1;
			ack_count <= 8'h00;
		end else begin
			if (go)
				dma_req_n <= 1'b0;
			else if ((!dma_ack_pin_n && dma_ack_oe) || bus_write)
				dma_req_n <= 1'b1;
			if (!dma_ack_pin_n && dma_ack_oe)
				ack_count <= ack_count + 8'h01;
		end
	end
	// Memory answers while the read strobe stands, shows the inverse otherwise
	assign bus_rdata = bus_read ? 32'h5a5a0000 : 32'ha5a5ffff;
endmodule
`default_nettype wire

/* File: tb/dma_address_mode_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ------
// Bench
// ------
module dma_address_mode_control_tb;
	logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, dma_req_n, dma_ack_pin_n;
	logic dma_ack_oe, bus_read, bus_write, address_mode_select, single_addr_direction, busy;
	logic [7:0] paddr, ack_count;
	logic [31:0] pwdata, prdata, bus_addr, bus_wdata, bus_rdata, seed, w;
	logic [64:0] q[$];
	logic [64:0] e;
	int fail_count, checked, i, k;
	dma_address_mode_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .dma_req_n, .dma_ack_pin_n, .dma_ack_oe, .bus_addr,
		.bus_read, .bus_write, .bus_wdata, .bus_rdata, .address_mode_select,
		.single_addr_direction, .busy);
	ack_side_model peer (.pclk, .presetn, .go, .dma_ack_pin_n, .dma_ack_oe, .bus_read,
		.bus_write, .dma_req_n, .bus_rdata, .ack_count);
	task check(input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// For reads d is the expected value and m the mask of bits compared
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, m);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wr ? d : $random(seed);
		@(posedge pclk);
		penable <= 1'b1;
		q.push_back({(a > 8'h14) || (a[1:0] != 2'h0), wr ? 32'hffffffff : m, wr ? 32'h0 : d});
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task xfer;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		for (k = 0; k < 60 && !(k > 4 && busy === 1'b0 && dma_req_n === 1'b1); k++)
			@(posedge pclk);
	endtask
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1) begin
			e = q.pop_front();
			check(prdata & e[63:32], e[31:0] & e[63:32]);
			check({31'h0, pslverr}, {31'h0, e[64]});
		end
	always @(posedge pclk) begin
		if (bus_read === 1'b1)
			check(bus_addr, 32'h100);
		if (bus_write === 1'b1)
			check(bus_addr, 32'h200);
		if (bus_write === 1'b1 && address_mode_select === 1'b0)
			check(bus_wdata, 32'h5a5a0000);
	end
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		seed = 32'hc9585eff;
		{presetn, psel, penable, pwrite, go, paddr, pwdata} = '0;
		fail_count = 0;
		checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 8'h00, 32'h0, 32'hffffffff);
		for (i = 0; i < 4; i++) begin
			w = $random(seed);
			w[31:30] = i[1:0];
			apb(1, 8'h00, w, 0);
			apb(0, 8'h00, w & 32'hc7339f9f, 32'hffffffff);
			apb(0, 8'h14, {w[31], w[31] & w[30], 2'h0}, 32'hc);
		end
		// Single with source, single with destination, dual with direction set
		for (i = 0; i < 3; i++) begin
			apb(1, 8'h04, 32'h100, 0);
			apb(1, 8'h08, 32'h200, 0);
			apb(1, 8'h0c, 32'h1, 0);
			apb(1, 8'h14, 32'h2, 0);
			apb(1, 8'h00, {i < 2, i > 0, 8'h0, 2'h2, 2'h0, (i == 1) ? 2'h3 : 2'h2, 16'h0}, 0);
			apb(1, 8'h10, 32'h3, 0);
			xfer();
			apb(0, 8'h04, (i != 1) ? 32'h101 : 32'h100, 32'hffffffff);
			apb(0, 8'h08, (i == 0) ? 32'h200 : (i == 1) ? 32'h1ff : 32'h201, 32'hffffffff);
			apb(0, 8'h0c, 32'h0, 32'hffff);
			apb(0, 8'h14, 32'h2, 32'h3);
			check({24'h0, ack_count}, (i < 2) ? i + 1 : 2);
		end
		apb(0, 8'h40, 32'h0, 32'hffffffff);
		tally_and_finish();
	end
endmodule
`default_nettype wire
